// >>> rtl/cluster_ctrl_pkg.sv
// Constants, register map and signal bundles for the logic cluster control block.
// Assumes a 32-bit APB master and byte addresses on an 8-bit paddr.
package cluster_ctrl_pkg;

  localparam int COLUMN_CLOCKS   = 4;
  localparam int CONTROL_SIGNALS = 10;
  localparam int MAX_CELLS       = 16;

  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_CELL_CLOCK  = 8'h04;
  localparam logic [7:0] ADDR_CELL_PRESET = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0C;

  localparam int STATUS_CTRL_LSB = 0;
  localparam int STATUS_CELL_LSB = 16;

  // Configuration word, bit 0 upward: first_sel, second_sel, clear_sel,
  // both_edges, push_back, power_up_high
  typedef struct packed {
    logic       power_up_high;
    logic       push_back;
    logic       both_edges;
    logic [1:0] clear_sel;
    logic [1:0] second_sel;
    logic [1:0] first_sel;
  } config_t;

  localparam int      CONFIG_WIDTH   = 9;
  localparam config_t CONFIG_RESET   = 9'h0A4;
  localparam logic    CELL_BIT_RESET = 1'b0;

  typedef struct packed {
    logic ena_first;
    logic ena_second;
    logic aclr_second;
    logic sclr;
    logic aload;
    logic sload;
    logic addnsub;
  } local_route_t;

  typedef struct packed {
    logic clk_first;
    logic clk_second;
    logic ena_first;
    logic ena_second;
    logic aclr_first;
    logic aclr_second;
    logic sclr;
    logic aload;
    logic sload;
    logic addnsub;
  } cluster_ctrl_t;

endpackage

// >>> rtl/logic_cluster.sv
// Control-signal generation for one logic cluster plus the cluster's cell registers.
// Assumes column clocks, local routing and cell inputs arrive asynchronously to pclk.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps

module logic_cluster
  import cluster_ctrl_pkg::*;
#(
  parameter int CELLS = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [COLUMN_CLOCKS-1:0] column_clock,
  input  wire local_route_t             local_route,
  input  wire logic [CELLS-1:0]         operand_a,
  input  wire logic [CELLS-1:0]         operand_b,
  input  wire logic [CELLS-1:0]         cell_fourth_data_input,
  output cluster_ctrl_t                 cluster_ctrl,
  output logic      [CELLS-1:0]         cell_q,
  output logic                          carry_out
);

  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_CONFIG) || (a == ADDR_CELL_CLOCK) ||
           (a == ADDR_CELL_PRESET) || (a == ADDR_STATUS);
  endfunction

  // Two-stage synchronisers for everything arriving from outside pclk
  logic [COLUMN_CLOCKS-1:0] col_meta_reg;
  logic [COLUMN_CLOCKS-1:0] col_sync_reg;
  local_route_t             route_meta_reg;
  local_route_t             route_sync_reg;
  logic [3*CELLS-1:0]       data_meta_reg;
  logic [3*CELLS-1:0]       data_sync_reg;
  logic [CELLS-1:0]         a_sync;
  logic [CELLS-1:0]         b_sync;
  logic [CELLS-1:0]         d3_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_meta_reg   <= '0;
      col_sync_reg   <= '0;
      route_meta_reg <= '0;
      route_sync_reg <= '0;
      data_meta_reg  <= '0;
      data_sync_reg  <= '0;
    end else begin
      col_meta_reg   <= column_clock;
      col_sync_reg   <= col_meta_reg;
      route_meta_reg <= local_route;
      route_sync_reg <= route_meta_reg;
      data_meta_reg  <= {cell_fourth_data_input, operand_b, operand_a};
      data_sync_reg  <= data_meta_reg;
    end
  end

  assign a_sync  = data_sync_reg[CELLS-1:0];
  assign b_sync  = data_sync_reg[2*CELLS-1:CELLS];
  assign d3_sync = data_sync_reg[3*CELLS-1:2*CELLS];

  // APB register file
  config_t          cfg_reg;
  config_t          cfg_next;
  logic [CELLS-1:0] cell_clock_reg;
  logic [CELLS-1:0] cell_clock_next;
  logic [CELLS-1:0] preset_reg;
  logic [CELLS-1:0] preset_next;
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic [31:0]      read_word;
  logic             wr_take;
  cluster_ctrl_t    ctrl_reg;
  logic [CELLS-1:0] cell_q_reg;

  always_comb begin
    wr_take         = psel && penable && pwrite && addr_known(paddr);
    cfg_next        = cfg_reg;
    cell_clock_next = cell_clock_reg;
    preset_next     = preset_reg;
    read_word       = 32'h0000_0000;
    unique case (paddr)
      ADDR_CONFIG:      read_word[CONFIG_WIDTH-1:0] = cfg_reg;
      ADDR_CELL_CLOCK:  read_word[CELLS-1:0] = cell_clock_reg;
      ADDR_CELL_PRESET: read_word[CELLS-1:0] = preset_reg;
      ADDR_STATUS: begin
        read_word[STATUS_CTRL_LSB +: CONTROL_SIGNALS] = ctrl_reg;
        read_word[STATUS_CELL_LSB +: CELLS]           = cell_q_reg;
      end
      default: read_word = 32'h0000_0000;
    endcase
    if (wr_take && paddr == ADDR_CONFIG) begin
      cfg_next = config_t'(pwdata[CONFIG_WIDTH-1:0]);
    end
    if (wr_take && paddr == ADDR_CELL_CLOCK) begin
      cell_clock_next = pwdata[CELLS-1:0];
    end
    if (wr_take && paddr == ADDR_CELL_PRESET) begin
      preset_next = pwdata[CELLS-1:0];
    end
    prdata_next = (psel && !penable && !pwrite) ? read_word : prdata_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg        <= CONFIG_RESET;
      cell_clock_reg <= {CELLS{CELL_BIT_RESET}};
      preset_reg     <= {CELLS{CELL_BIT_RESET}};
      prdata_reg     <= 32'h0000_0000;
    end else begin
      cfg_reg        <= cfg_next;
      cell_clock_reg <= cell_clock_next;
      preset_reg     <= preset_next;
      prdata_reg     <= prdata_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!addr_known(paddr) || (pwrite && paddr == ADDR_STATUS));

  // Cluster-wide control signal selection
  cluster_ctrl_t ctrl_next;
  logic [1:0]    clk_prev_reg;
  logic [1:0]    clk_prev_next;

  always_comb begin
    ctrl_next.clk_first   = col_sync_reg[cfg_reg.first_sel];
    ctrl_next.clk_second  = cfg_reg.both_edges ? !col_sync_reg[cfg_reg.first_sel]
                                               : col_sync_reg[cfg_reg.second_sel];
    ctrl_next.aclr_first  = col_sync_reg[cfg_reg.clear_sel];
    ctrl_next.ena_first   = route_sync_reg.ena_first;
    ctrl_next.ena_second  = route_sync_reg.ena_second;
    ctrl_next.aclr_second = route_sync_reg.aclr_second;
    ctrl_next.sclr        = route_sync_reg.sclr;
    ctrl_next.aload       = route_sync_reg.aload;
    ctrl_next.sload       = route_sync_reg.sload;
    ctrl_next.addnsub     = route_sync_reg.addnsub;
    clk_prev_next         = {ctrl_reg.clk_second, ctrl_reg.clk_first};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= '0;
      clk_prev_reg <= 2'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      clk_prev_reg <= clk_prev_next;
    end
  end

  assign cluster_ctrl = ctrl_reg;

  // Cell registers and add/subtract chain
  logic             evt_first;
  logic             evt_second;
  logic             aclr_any;
  logic [CELLS-1:0] evt_cell;
  logic [CELLS-1:0] inv_bit;
  logic [CELLS-1:0] one_bit;
  logic [CELLS-1:0] sum_bit;
  logic [CELLS-1:0] b_eff;
  logic [CELLS-1:0] store_reg;
  logic [CELLS-1:0] store_next;
  logic [CELLS-1:0] cell_q_next;
  logic             carry;
  logic             carry_reg;

  always_comb begin
    // A disabled enable suppresses the edge entirely
    evt_first  = ctrl_reg.clk_first && !clk_prev_reg[0] && ctrl_reg.ena_first;
    evt_second = ctrl_reg.clk_second && !clk_prev_reg[1] && ctrl_reg.ena_second;
    aclr_any   = ctrl_reg.aclr_first || ctrl_reg.aclr_second;
    carry      = ctrl_reg.addnsub;
    for (int i = 0; i < CELLS; i++) begin
      b_eff[i]   = b_sync[i] ^ ctrl_reg.addnsub;
      sum_bit[i] = a_sync[i] ^ b_eff[i] ^ carry;
      carry      = (a_sync[i] & b_eff[i]) | (carry & (a_sync[i] ^ b_eff[i]));
    end
    for (int i = 0; i < CELLS; i++) begin
      evt_cell[i]   = cell_clock_reg[i] ? evt_second : evt_first;
      inv_bit[i]    = preset_reg[i] && cfg_reg.push_back;
      one_bit[i]    = preset_reg[i] && (!cfg_reg.push_back || cfg_reg.power_up_high);
      store_next[i] = store_reg[i];
      if (aclr_any) begin
        store_next[i] = 1'b0;
      end else if (ctrl_reg.aload) begin
        store_next[i] = one_bit[i] ? !inv_bit[i] : (d3_sync[i] ^ inv_bit[i]);
      end else if (evt_cell[i]) begin
        if (ctrl_reg.sclr) begin
          store_next[i] = inv_bit[i];
        end else if (ctrl_reg.sload) begin
          store_next[i] = d3_sync[i] ^ inv_bit[i];
        end else begin
          store_next[i] = sum_bit[i] ^ inv_bit[i];
        end
      end
      cell_q_next[i] = store_next[i] ^ inv_bit[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_reg  <= {CELLS{CELL_BIT_RESET}};
      cell_q_reg <= {CELLS{CELL_BIT_RESET}};
      carry_reg  <= 1'b0;
    end else begin
      store_reg  <= store_next;
      cell_q_reg <= cell_q_next;
      carry_reg  <= carry;
    end
  end

  assign cell_q    = cell_q_reg;
  assign carry_out = carry_reg;

  // Reference for the chain: a + b or a - b, carry out on top
  logic [CELLS:0] ref_sum;
  assign ref_sum = {1'b0, a_sync} + {1'b0, b_eff} + {{CELLS{1'b0}}, ctrl_reg.addnsub};

  a_route_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> {ctrl_reg.ena_first, ctrl_reg.ena_second, ctrl_reg.aclr_second, ctrl_reg.sclr,
              ctrl_reg.aload, ctrl_reg.sload, ctrl_reg.addnsub} == $past(route_sync_reg))
    else $error("routed control signals not copied from local routing");

  a_first_mux: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ctrl_reg.clk_first == $past(col_sync_reg[cfg_reg.first_sel]))
    else $error("first cluster clock not from selected column clock");

  a_clear_sources: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ctrl_reg.aclr_first == $past(col_sync_reg[cfg_reg.clear_sel]) &&
             ctrl_reg.aclr_second == $past(route_sync_reg.aclr_second))
    else $error("asynchronous clear sources wrong");

  a_both_edges: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_reg.both_edges && $stable(cfg_reg) |=> ctrl_reg.clk_second == !ctrl_reg.clk_first)
    else $error("both-edge use does not occupy second cluster clock");

  a_add_sub: assert property (
    @(posedge pclk) disable iff (!presetn) 1'b1 |=> carry_out == $past(ref_sum[CELLS]))
    else $error("add/subtract chain carry wrong");

  for (genvar g = 0; g < CELLS; g++) begin : g_cell_check
    a_enable_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !aclr_any && !ctrl_reg.aload &&
      (cell_clock_reg[g] ? !ctrl_reg.ena_second : !ctrl_reg.ena_first)
      |=> $stable(store_reg[g]))
      else $error("cell register changed with its enable low");

    a_clear_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      aclr_any && (ctrl_reg.sload || ctrl_reg.aload) |=> cell_q_reg[g] == $past(inv_bit[g]))
      else $error("clear did not override load");

    a_push_back: assert property (
      @(posedge pclk) disable iff (!presetn)
      aclr_any && inv_bit[g] |=> cell_q_reg[g] && !store_reg[g])
      else $error("inverted preset not realised by clear");

    a_aload_one: assert property (
      @(posedge pclk) disable iff (!presetn)
      !aclr_any && ctrl_reg.aload && one_bit[g] |=> cell_q_reg[g])
      else $error("asynchronous load preset did not give one");

    a_aload_data: assert property (
      @(posedge pclk) disable iff (!presetn)
      !aclr_any && ctrl_reg.aload && !one_bit[g] |=> cell_q_reg[g] == $past(d3_sync[g]))
      else $error("asynchronous load data not from fourth input");
  end

endmodule // logic_cluster

// >>> tb/cell_event_counter.sv
// Far-side model: counts clock events that the cluster's cells would act on.
// Assumes cluster_ctrl is registered on pclk.
`timescale 1ns/100ps
module cell_event_counter
  import cluster_ctrl_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire cluster_ctrl_t cluster_ctrl,
  output logic [15:0]        first_events,
  output logic [15:0]        second_events
);
  logic prev_first;
  logic prev_second;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_first    <= 1'b0;
      prev_second   <= 1'b0;
      first_events  <= 16'h0000;
      second_events <= 16'h0000;
    end else begin
      prev_first  <= cluster_ctrl.clk_first;
      prev_second <= cluster_ctrl.clk_second;
      // Rising clock counts only while its paired enable is high
      if (cluster_ctrl.clk_first && !prev_first && cluster_ctrl.ena_first) begin
        first_events <= first_events + 16'h0001;
      end
      if (cluster_ctrl.clk_second && !prev_second && cluster_ctrl.ena_second) begin
        second_events <= second_events + 16'h0001;
      end
    end
  end
endmodule // cell_event_counter

// >>> tb/test_logic_cluster.sv
// Self-checking bench for the logic cluster control block.
// Assumes zero-wait APB and three pclk edges from input to cluster_ctrl.
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module test_logic_cluster;
  import cluster_ctrl_pkg::*;
  localparam logic [3:0] PAT = 4'hD;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h00000000;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    column_clock = 4'h0;
  local_route_t  local_route = '0;
  logic [7:0]    operand_a = 8'h00;
  logic [7:0]    operand_b = 8'h00;
  logic [7:0]    fourth = 8'h00;
  cluster_ctrl_t cluster_ctrl;
  logic [7:0]    cell_q;
  logic          carry_out;
  logic [15:0]   first_events;
  logic [15:0]   second_events;
  logic [31:0]   rdata;
  logic          rerr;
  logic [15:0]   n0;
  logic [6:0]    routed;
  assign routed = {cluster_ctrl.ena_first, cluster_ctrl.ena_second, cluster_ctrl.aclr_second,
                   cluster_ctrl.sclr, cluster_ctrl.aload, cluster_ctrl.sload,
                   cluster_ctrl.addnsub};
  int            errors = 0;
  int            n_checks = 0;
  int            cycles = 0;
  always #4 pclk = ~pclk;
  logic_cluster #(.CELLS(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .column_clock(column_clock),
    .local_route(local_route), .operand_a(operand_a), .operand_b(operand_b),
    .cell_fourth_data_input(fourth), .cluster_ctrl(cluster_ctrl), .cell_q(cell_q),
    .carry_out(carry_out));
  cell_event_counter pc (.pclk(pclk), .presetn(presetn), .cluster_ctrl(cluster_ctrl),
    .first_events(first_events), .second_events(second_events));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends on the first pclk edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(input int f, s, c, input logic both, push, pu);
    return {23'h000000, pu, push, both, c[1:0], s[1:0], f[1:0]};
  endfunction
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    @(posedge pclk) column_clock[k] <= 1'b1;
    settle();
    column_clock[k] <= 1'b0;
    settle();
  endtask
  task automatic step(input logic [6:0] r, input logic [7:0] a, b, f, input int k,
                      input logic [7:0] exp);
    @(posedge pclk);
    local_route <= local_route_t'(r); operand_a <= a; operand_b <= b; fourth <= f;
    settle();
    if (k >= 0) pulse(k);
    `CHECK("cell_q", exp, cell_q)
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CONFIG, 0);       `CHECK("config", 32'h000000A4, rdata)
    apb(0, ADDR_CELL_CLOCK, 0);   `CHECK("cell_clock", 32'h00000000, rdata)
    apb(1, ADDR_CELL_PRESET, 32'hFFFFFFFF);
    apb(0, ADDR_CELL_PRESET, 0);  `CHECK("cell_preset", 32'h000000FF, rdata)
    apb(0, 8'h10, 0);             `CHECK("unmapped", 32'h00000000, rdata)
    `CHECK("unmapped_err", 1'b1, rerr)
    apb(1, ADDR_STATUS, 32'hFFFFFFFF); `CHECK("status_err", 1'b1, rerr)
    end_test("registers");
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CONFIG, cfg(i, (i + 1) % 4, (i + 2) % 4, 1'b0, 1'b1, 1'b0));
      @(posedge pclk) column_clock <= PAT;
      settle();
      `CHECK("clk_first", PAT[i], cluster_ctrl.clk_first)
      `CHECK("clk_second", PAT[(i + 1) % 4], cluster_ctrl.clk_second)
      `CHECK("aclr_first", PAT[(i + 2) % 4], cluster_ctrl.aclr_first)
      column_clock <= 4'h0;
    end
    apb(1, ADDR_CONFIG, cfg(0, 1, 2, 1'b1, 1'b1, 1'b0));
    settle();                     `CHECK("both_low", 1'b1, cluster_ctrl.clk_second)
    column_clock <= 4'h1;
    settle();                     `CHECK("both_high", 1'b0, cluster_ctrl.clk_second)
    column_clock <= 4'h0;
    end_test("selection");
    apb(1, ADDR_CONFIG, cfg(0, 1, 2, 1'b0, 1'b0, 1'b0));
    step(7'h55, 8'h00, 8'h00, 8'h00, -1, 8'h00);
    `CHECK("route_a", 7'h55, routed)
    step(7'h2A, 8'h00, 8'h00, 8'h00, -1, 8'h00);
    apb(0, ADDR_STATUS, 0);       `CHECK("status", 32'h0000004A, rdata)
    end_test("routing");
    apb(1, ADDR_CELL_PRESET, 32'h0000000F);
    step(7'h04, 8'h00, 8'h00, 8'h50, -1, 8'h5F);
    apb(1, ADDR_CONFIG, cfg(0, 1, 2, 1'b0, 1'b1, 1'b0));
    step(7'h04, 8'h00, 8'h00, 8'h50, -1, 8'h50);
    apb(1, ADDR_CONFIG, cfg(0, 1, 2, 1'b0, 1'b1, 1'b1));
    step(7'h04, 8'h00, 8'h00, 8'h50, -1, 8'h5F);
    step(7'h14, 8'h00, 8'h00, 8'h50, -1, 8'h0F);
    apb(1, ADDR_CONFIG, cfg(0, 1, 2, 1'b0, 1'b0, 1'b0));
    step(7'h14, 8'h00, 8'h00, 8'h50, -1, 8'h00);
    // Load ones first so that the column clear below has something to clear
    step(7'h04, 8'h00, 8'h00, 8'h50, -1, 8'h5F);
    @(posedge pclk) local_route <= '0;
    column_clock <= 4'h4;
    settle();                     `CHECK("aclr_col", 8'h00, cell_q)
    column_clock <= 4'h0;
    end_test("preset_clear");
    apb(1, ADDR_CELL_PRESET, 0);
    n0 = first_events;
    step(7'h40, 8'hF0, 8'h20, 8'h00, 0, 8'h10);
    `CHECK("carry_add", 1'b1, carry_out)
    step(7'h41, 8'h35, 8'h12, 8'h00, 0, 8'h23);
    step(7'h41, 8'h12, 8'h35, 8'h00, 0, 8'hDD);
    `CHECK("carry_sub", 1'b0, carry_out)
    step(7'h00, 8'h01, 8'h01, 8'h00, 0, 8'hDD);
    `CHECK("events", n0 + 16'h0003, first_events)
    end_test("arithmetic");
    apb(1, ADDR_CELL_CLOCK, 32'h000000F0);
    step(7'h40, 8'h11, 8'h22, 8'h00, 0, 8'hD3);
    step(7'h20, 8'h11, 8'h22, 8'h00, 1, 8'h33);
    apb(1, ADDR_CELL_CLOCK, 0);
    step(7'h48, 8'h11, 8'h22, 8'h00, 0, 8'h00);
    step(7'h42, 8'h11, 8'h22, 8'h50, 0, 8'h50);
    end_test("pairing");
    final_report();
  end
endmodule // test_logic_cluster
